// ===== hdl/ssdm_cfg.svh
// Purpose: constants of the supply and short-circuit diagnostic monitor
// Assumes: 40 MHz system clock
// Notes:   one define per number; the package holds the types
`ifndef SSDM_CFG_SVH
`define SSDM_CFG_SVH

`define SSDM_CLK_HZ      40000000
`define SSDM_MS_PER_S    1000
`define SSDM_TICK_CYC    (`SSDM_CLK_HZ / `SSDM_MS_PER_S)
`define SSDM_RETRY_MS    8'h64
`define SSDM_FILT_RST    8'h50
`define SSDM_NPORT       8
`define SSDM_NEV         19

// event vector layout: supplies low, then sensor shorts, then output errors
`define SSDM_EV_US       0
`define SSDM_EV_UL       1
`define SSDM_EV_AUX      2
`define SSDM_EV_LS       3
`define SSDM_EV_DO       11

// diagnostic channel numbers and codes
`define SSDM_CH_GLOBAL   16'h8000
`define SSDM_CH_FIRST    16'h0001
`define SSDM_CODE_US     16'h0002
`define SSDM_CODE_UL     16'h0118
`define SSDM_CODE_AUX    16'h180e
`define SSDM_CODE_LS     16'h1806
`define SSDM_CODE_DO     16'h1811

// register byte addresses
`define SSDM_A_CTRL      8'h00
`define SSDM_A_FILT      8'h04
`define SSDM_A_STAT      8'h08
`define SSDM_A_MASK      8'h0c
`define SSDM_A_LIVE      8'h10
`define SSDM_A_DIAG      8'h14

// control bits
`define SSDM_C_US_EN     0
`define SSDM_C_UL_EN     1
`define SSDM_C_AUX_EN    2
`define SSDM_C_RST_MODE  3
`define SSDM_CTRL_RST    4'h1

`define SSDM_RESP_OK     2'h0
`define SSDM_RESP_ERR    2'h2

`endif

// ===== hdl/ssdm_pkg.sv
// Purpose: types of the supply and short-circuit diagnostic monitor
// Assumes: ssdm_cfg.svh for all figures
// Notes:   led state and diagnostic record carriers
package ssdm_pkg;

  typedef enum logic [1:0] {
    SSDM_LED_OFF,
    SSDM_LED_GREEN,
    SSDM_LED_RED
  } ssdm_led_t;

  typedef struct packed {
    logic [15:0] channel;
    logic [15:0] code;
  } ssdm_diag_t;

  typedef enum logic {
    SSDM_TX_IDLE,
    SSDM_TX_SEND
  } ssdm_tx_t;

endpackage

// ===== hdl/ssdm_monitor.sv
// Purpose: supply and port short-circuit diagnostic monitor, axi4-lite regs
// Assumes: comparator and short flags synchronous to i_sys_clk
// Notes:   diagnostics leave one at a time over a valid/ready pair
//
// Contract
// (RULE_01) system supply out of range: code 0x0002
// (RULE_02) system alarms off: led off, no diagnostic
// (RULE_03) system alarms on: led red plus diagnostic
// (RULE_04) actuator supply fault, enabled: code 0x0118
// (RULE_05) actuator and aux alarm enables reset off
// (RULE_06) supply fault also flags active output ports
// (RULE_07) aux supply fault, enabled: code 0x180e
// (RULE_08) actuator led shows actuator or aux fault
// (RULE_09) sensor supply short: port code 0x1806, led
// (RULE_10) auto mode: force off, retry periodically
// (RULE_11) reset mode: stay off until commanded low
// (RULE_12) suppress errors after output rising edge
// (RULE_13) output short: port code 0x1811, led
// (RULE_14) window counts 1 ms ticks; zero disables
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "ssdm_cfg.svh"

module ssdm_monitor
  import ssdm_pkg::*;
#(
  parameter int unsigned P_TICK_CYC = `SSDM_TICK_CYC  // cycles per 1 ms
) (
  input  wire logic        i_sys_clk,       // system clock
  input  wire logic        i_rstn,          // async reset, active low
  input  wire logic        i_us_fault,      // system supply out of range
  input  wire logic        i_ul_fault,      // actuator supply out of range
  input  wire logic        i_aux_fault,     // aux supply out of range
  input  wire logic [7:0]  i_ls_short,      // sensor supply short per port
  input  wire logic [7:0]  i_do_short,      // channel a output short
  input  wire logic [7:0]  i_do_cmd,        // commanded output level
  output logic [7:0]       o_do_en,         // driven output level
  output ssdm_led_t        o_us_led,        // system supply indicator
  output ssdm_led_t        o_act_led,       // actuator supply indicator
  output logic [7:0]       o_port_fault_indicator, // red port leds
  output logic             o_diag_valid,    // diagnostic offered
  output ssdm_diag_t       o_diag,          // diagnostic record
  input  wire logic        i_diag_ready,    // controller takes record
  output logic             o_irq,           // unmasked status pending
  input  wire logic [7:0]  i_axi_awaddr,    // write address
  input  wire logic        i_axi_awvalid,   // write address valid
  output logic             o_axi_awready,   // write address ready
  input  wire logic [31:0] i_axi_wdata,     // write data
  input  wire logic [3:0]  i_axi_wstrb,     // write strobes
  input  wire logic        i_axi_wvalid,    // write data valid
  output logic             o_axi_wready,    // write data ready
  output logic [1:0]       o_axi_bresp,     // write response
  output logic             o_axi_bvalid,    // write response valid
  input  wire logic        i_axi_bready,    // write response ready
  input  wire logic [7:0]  i_axi_araddr,    // read address
  input  wire logic        i_axi_arvalid,   // read address valid
  output logic             o_axi_arready,   // read address ready
  output logic [31:0]      o_axi_rdata,     // read data
  output logic [1:0]       o_axi_rresp,     // read response
  output logic             o_axi_rvalid,    // read data valid
  input  wire logic        i_axi_rready     // read data ready
);

  localparam int NEV = `SSDM_NEV;
  localparam int NP  = `SSDM_NPORT;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == `SSDM_A_CTRL) || (a == `SSDM_A_FILT) ||
           (a == `SSDM_A_STAT) || (a == `SSDM_A_MASK) ||
           (a == `SSDM_A_LIVE) || (a == `SSDM_A_DIAG);
  endfunction

  function automatic ssdm_diag_t diag_of(input int idx);
    ssdm_diag_t d;
    d.channel = `SSDM_CH_GLOBAL;
    d.code    = `SSDM_CODE_US;
    if (idx == `SSDM_EV_UL) begin
      d.code = `SSDM_CODE_UL;
    end else if (idx == `SSDM_EV_AUX) begin
      d.code = `SSDM_CODE_AUX;
    end else if (idx >= `SSDM_EV_DO) begin
      d.channel = `SSDM_CH_FIRST + 16'(idx - `SSDM_EV_DO);
      d.code    = `SSDM_CODE_DO;
    end else if (idx >= `SSDM_EV_LS) begin
      d.channel = `SSDM_CH_FIRST + 16'(idx - `SSDM_EV_LS);
      d.code    = `SSDM_CODE_LS;
    end
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers and shared state
  logic [3:0]     ctrl_q;
  logic [7:0]     filt_ms_q;
  logic [NEV-1:0] stat_q;
  logic [NEV-1:0] mask_q;
  logic [NEV-1:0] pend_q;
  logic [NEV-1:0] cond_q;
  logic [NEV-1:0] cond;
  logic [NEV-1:0] ev;
  logic [NP-1:0]  do_err;
  logic [NP-1:0]  filt_act;
  logic [NP-1:0]  do_off;
  logic [31:0]    tick_cnt_q;
  logic           tick_q;
  logic           aw_have_q;
  logic           w_have_q;
  logic [7:0]     aw_addr_q;
  logic [31:0]    w_data_q;
  logic [3:0]     w_strb_q;
  logic           wr_fire;
  logic           rd_fire;
  logic           stat_clr;
  ssdm_tx_t       tx_q;
  ssdm_diag_t     last_q;

  assign wr_fire  = aw_have_q && w_have_q && !o_axi_bvalid;
  assign rd_fire  = i_axi_arvalid && o_axi_arready;
  assign stat_clr = rd_fire && (i_axi_araddr == `SSDM_A_STAT);

  ////////////////////////////////////////////////////////////////////////////
  // 1 ms tick for filter and retry timers
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == P_TICK_CYC - 1) begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b1; // RULE_14
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      tick_q     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-port channel a output control
  generate
    for (genvar p = 0; p < NP; p++) begin : g_port
      logic       off_q;
      logic [7:0] filt_q;
      logic [7:0] retry_q;
      logic       prev_q;
      logic       rise;
      logic       fault;

      assign rise        = o_do_en[p] && !prev_q;
      assign filt_act[p] = (filt_q != 8'h0) || (rise && filt_ms_q != 8'h0);
      // supply loss under an active output is a port error as well
      assign fault  = o_do_en[p] &&
                      (i_do_short[p] || i_ul_fault || i_aux_fault); // RULE_06
      assign do_err[p] = fault && !filt_act[p]; // RULE_12
      assign do_off[p] = off_q;

      always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          prev_q <= 1'b0;
          filt_q <= 8'h0;
        end else begin
          prev_q <= o_do_en[p];
          if (rise) begin
            filt_q <= filt_ms_q; // RULE_12
          end else if (tick_q && filt_q != 8'h0) begin
            filt_q <= filt_q - 8'h1; // RULE_14
          end
        end
      end

      always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          off_q   <= 1'b0;
          retry_q <= 8'h0;
        end else if (do_err[p]) begin
          off_q   <= 1'b1; // RULE_10
          retry_q <= `SSDM_RETRY_MS;
        end else if (ctrl_q[`SSDM_C_RST_MODE]) begin
          if (!i_do_cmd[p]) begin
            off_q <= 1'b0; // RULE_11
          end
        end else if (off_q && tick_q) begin
          if (retry_q <= 8'h1) begin
            off_q <= 1'b0; // RULE_10
          end
          retry_q <= retry_q - 8'h1;
        end
      end

      always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          o_do_en[p] <= 1'b0;
        end else begin
          o_do_en[p] <= i_do_cmd[p] && !off_q && !do_err[p]; // RULE_10 RULE_11
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // fault conditions, events, sticky status and pending diagnostics
  always_comb begin
    cond                 = '0;
    cond[`SSDM_EV_US]    = i_us_fault && ctrl_q[`SSDM_C_US_EN]; // RULE_01 RULE_02
    cond[`SSDM_EV_UL]    = i_ul_fault && ctrl_q[`SSDM_C_UL_EN]; // RULE_04
    cond[`SSDM_EV_AUX]   = i_aux_fault && ctrl_q[`SSDM_C_AUX_EN]; // RULE_07
    cond[`SSDM_EV_LS +: NP] = i_ls_short; // RULE_09
    cond[`SSDM_EV_DO +: NP] = do_err; // RULE_13
  end
  assign ev = cond & ~cond_q;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cond_q <= '0;
    end else begin
      cond_q <= cond;
    end
  end

  // a new event beats a clearing read in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_clr ? '0 : stat_q) | ev;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(((stat_clr ? '0 : stat_q) | ev) & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // diagnostic sender, lowest event index first
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pend_q       <= '0;
      tx_q         <= SSDM_TX_IDLE;
      o_diag_valid <= 1'b0;
      o_diag       <= '0;
      last_q       <= '0;
    end else begin
      case (tx_q)
        SSDM_TX_IDLE: begin
          pend_q <= pend_q | ev;
          for (int i = NEV - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
              o_diag       <= diag_of(i); // RULE_01 RULE_04 RULE_07 RULE_09 RULE_13
              o_diag_valid <= 1'b1;
              tx_q         <= SSDM_TX_SEND;
              pend_q       <= (pend_q | ev) & ~(NEV'(1) << i);
            end
          end
        end
        SSDM_TX_SEND: begin
          pend_q <= pend_q | ev;
          if (i_diag_ready) begin
            o_diag_valid <= 1'b0;
            last_q       <= o_diag;
            tx_q         <= SSDM_TX_IDLE;
          end
        end
        default: begin
          tx_q <= SSDM_TX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicators
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_us_led               <= SSDM_LED_OFF;
      o_act_led              <= SSDM_LED_OFF;
      o_port_fault_indicator <= 8'h0;
    end else begin
      if (!i_us_fault) begin
        o_us_led <= SSDM_LED_GREEN;
      end else if (ctrl_q[`SSDM_C_US_EN]) begin
        o_us_led <= SSDM_LED_RED; // RULE_03
      end else begin
        o_us_led <= SSDM_LED_OFF; // RULE_02
      end
      if (!i_ul_fault && !i_aux_fault) begin
        o_act_led <= SSDM_LED_GREEN;
      end else if ((i_ul_fault && ctrl_q[`SSDM_C_UL_EN]) ||
                   (i_aux_fault && ctrl_q[`SSDM_C_AUX_EN])) begin
        o_act_led <= SSDM_LED_RED; // RULE_08
      end else begin
        o_act_led <= SSDM_LED_OFF; // RULE_08
      end
      // a forced-off port stays lit, else the led would only flash once
      o_port_fault_indicator <= i_ls_short | do_err | do_off; // RULE_09 RULE_13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write side
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 8'h0;
      w_data_q      <= 32'h0;
      w_strb_q      <= 4'h0;
      o_axi_awready <= 1'b1;
      o_axi_wready  <= 1'b1;
      o_axi_bvalid  <= 1'b0;
      o_axi_bresp   <= `SSDM_RESP_OK;
    end else begin
      if (i_axi_awvalid && o_axi_awready) begin
        aw_have_q     <= 1'b1;
        aw_addr_q     <= i_axi_awaddr;
        o_axi_awready <= 1'b0;
      end
      if (i_axi_wvalid && o_axi_wready) begin
        w_have_q     <= 1'b1;
        w_data_q     <= i_axi_wdata;
        w_strb_q     <= i_axi_wstrb;
        o_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        o_axi_bvalid <= 1'b1;
        o_axi_bresp  <= is_mapped(aw_addr_q) ? `SSDM_RESP_OK
                                             : `SSDM_RESP_ERR;
      end
      if (o_axi_bvalid && i_axi_bready) begin
        o_axi_bvalid  <= 1'b0;
        o_axi_awready <= 1'b1;
        o_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_q    <= `SSDM_CTRL_RST; // RULE_05
      filt_ms_q <= `SSDM_FILT_RST; // RULE_12
      mask_q    <= '0;
    end else if (wr_fire) begin
      case (aw_addr_q)
        `SSDM_A_CTRL: begin
          ctrl_q <= 4'(merge(32'(ctrl_q), w_data_q, w_strb_q)); // RULE_05
        end
        `SSDM_A_FILT: begin
          filt_ms_q <= 8'(merge(32'(filt_ms_q), w_data_q, w_strb_q));
        end
        `SSDM_A_MASK: begin
          mask_q <= NEV'(merge(32'(mask_q), w_data_q, w_strb_q));
        end
        default: begin
          mask_q <= mask_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read side; status clears when it is read
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_axi_arready <= 1'b1;
      o_axi_rvalid  <= 1'b0;
      o_axi_rdata   <= 32'h0;
      o_axi_rresp   <= `SSDM_RESP_OK;
    end else if (rd_fire) begin
      o_axi_arready <= 1'b0;
      o_axi_rvalid  <= 1'b1;
      o_axi_rresp   <= is_mapped(i_axi_araddr) ? `SSDM_RESP_OK
                                               : `SSDM_RESP_ERR;
      case (i_axi_araddr)
        `SSDM_A_CTRL: o_axi_rdata <= 32'(ctrl_q);
        `SSDM_A_FILT: o_axi_rdata <= 32'(filt_ms_q);
        `SSDM_A_STAT: o_axi_rdata <= 32'(stat_q);
        `SSDM_A_MASK: o_axi_rdata <= 32'(mask_q);
        `SSDM_A_LIVE: o_axi_rdata <= {5'h0, i_aux_fault, i_ul_fault,
                                      i_us_fault, filt_act, do_err, o_do_en};
        `SSDM_A_DIAG: o_axi_rdata <= last_q;
        default:      o_axi_rdata <= 32'h0;
      endcase
    end else if (o_axi_rvalid && i_axi_rready) begin
      o_axi_rvalid  <= 1'b0;
      o_axi_arready <= 1'b1;
    end
  end

endmodule // ssdm_monitor

// ===== verification/ssdm_chk.sv
// Purpose: port checks of the diagnostic monitor
// Assumes: ssdm_pkg compiled first
// Notes:   bound into every ssdm_monitor instance
`timescale 1ns/1ps
`include "ssdm_cfg.svh"
module ssdm_chk
  import ssdm_pkg::*;
#(
  parameter int unsigned P_TICK_CYC = 4  // cycles per 1 ms
) (
  input wire logic       i_sys_clk,              // clock
  input wire logic       i_rstn,                 // reset, active low
  input wire logic       i_us_fault,             // system supply fault
  input wire logic       i_ul_fault,             // actuator supply fault
  input wire logic       i_aux_fault,            // aux supply fault
  input wire logic [7:0] i_ls_short,             // sensor supply shorts
  input wire logic [7:0] i_do_short,             // output shorts
  input wire logic [7:0] i_do_cmd,               // commanded outputs
  input wire logic [7:0] o_do_en,                // driven outputs
  input wire ssdm_led_t  o_us_led,               // system led
  input wire ssdm_led_t  o_act_led,              // actuator led
  input wire logic [7:0] o_port_fault_indicator, // port leds
  input wire logic       o_diag_valid,           // record offered
  input wire ssdm_diag_t o_diag,                 // record
  input wire logic       i_diag_ready            // record taken
);
  // longest window plus slack; a short held longer means a stuck output
  localparam int LIM = 256 * P_TICK_CYC + 8;
  logic [7:0]  hit_q;
  logic [15:0] run_q;
  wire  [7:0]  hit = o_do_en & i_do_short;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hit_q <= 8'h00;
      run_q <= 16'h0000;
    end else begin
      hit_q <= hit;
      run_q <= (hit != 8'h00 && hit == hit_q) ? run_q + 16'h0001 : 16'h0000;
    end
  end
  a_diag_hold: assert property (
    o_diag_valid && !i_diag_ready |=> o_diag_valid && $stable(o_diag))
    else $error("diagnostic withdrawn before taken");
  a_glob_code: assert property (
    o_diag_valid && o_diag.channel == `SSDM_CH_GLOBAL |-> o_diag.code inside
    {`SSDM_CODE_US, `SSDM_CODE_UL, `SSDM_CODE_AUX})
    else $error("global diagnostic with wrong code");
  a_port_code: assert property (
    o_diag_valid && o_diag.channel != `SSDM_CH_GLOBAL |->
    o_diag.channel inside {[1:8]} &&
    o_diag.code inside {`SSDM_CODE_LS, `SSDM_CODE_DO})
    else $error("port diagnostic with wrong channel or code");
  a_us_led: assert property (
    i_us_fault [*3] |-> o_us_led != SSDM_LED_GREEN)
    else $error("system led green during fault");
  a_us_green: assert property (
    (!i_us_fault) [*3] |-> o_us_led == SSDM_LED_GREEN)
    else $error("system led not green without fault");
  a_act_led: assert property (
    (i_ul_fault || i_aux_fault) [*3] |-> o_act_led != SSDM_LED_GREEN)
    else $error("actuator led green during fault");
  a_ls_led: assert property (
    i_ls_short != 8'h00 ##1 $stable(i_ls_short) ##1 $stable(i_ls_short)
    |-> (o_port_fault_indicator & i_ls_short) == i_ls_short)
    else $error("port led dark on sensor short");
  a_out_off: assert property (run_q < LIM)
    else $error("shorted output left on past the window");
  a_out_cmd: assert property (
    (o_do_en & ~$past(o_do_en) & ~$past(i_do_cmd) & ~$past(i_do_cmd, 2))
    == 8'h00)
    else $error("output rose without command");
endmodule // ssdm_chk

bind ssdm_monitor ssdm_chk #(.P_TICK_CYC(P_TICK_CYC)) u_chk (.*);

// ===== verification/ssdm_ctrl_model.sv
// Purpose: controller side taking diagnostic records
// Assumes: a record stands until taken
// Notes:   stall per record set by the bench
`timescale 1ns/1ps
module ssdm_ctrl_model (
  input  wire logic       i_clk,   // system clock
  input  wire logic       i_rstn,  // reset, active low
  input  wire logic       i_valid, // record offered
  input  wire logic [3:0] i_stall, // cycles to wait before taking
  output logic            o_ready  // record taken at next edge
);
  logic [3:0] wait_q;
  // ready only while a record stands, so a dropped valid is not masked
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_q  <= 4'h0;
      o_ready <= 1'b0;
    end else if (o_ready || !i_valid) begin
      wait_q  <= 4'h0;
      o_ready <= 1'b0;
    end else if (wait_q >= i_stall) begin
      o_ready <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule // ssdm_ctrl_model

// ===== verification/testbench.sv
// Purpose: self-checking bench of the diagnostic monitor
// Assumes: 4 cycles stand for 1 ms
// Notes:   random ports and controller stalls from a fixed seed
`timescale 1ns/1ps
`include "ssdm_cfg.svh"
module testbench;
  import ssdm_pkg::*;
  logic        i_sys_clk, i_rstn, i_us_fault, i_ul_fault, i_aux_fault;
  logic        i_diag_ready, o_diag_valid, o_irq;
  logic [7:0]  i_ls_short, i_do_short, i_do_cmd, o_do_en;
  logic [7:0]  o_port_fault_indicator, i_axi_awaddr, i_axi_araddr;
  ssdm_led_t   o_us_led, o_act_led;
  ssdm_diag_t  o_diag;
  logic        i_axi_awvalid, o_axi_awready, i_axi_wvalid, o_axi_wready;
  logic        o_axi_bvalid, i_axi_bready, i_axi_arvalid, o_axi_arready;
  logic        o_axi_rvalid, i_axi_rready;
  logic [31:0] i_axi_wdata, o_axi_rdata, seed, rd_d;
  logic [3:0]  i_axi_wstrb, stall;
  logic [1:0]  o_axi_bresp, o_axi_rresp, rd_r;
  int          n_fail, samples_checked, p, k;
  ssdm_diag_t  q[$];

  ssdm_monitor #(.P_TICK_CYC(4)) uut (.*);
  ssdm_ctrl_model u_ctrl (.i_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_valid(o_diag_valid), .i_stall(stall), .o_ready(i_diag_ready));

  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    if (o_diag_valid === 1'b1 && i_diag_ready === 1'b1) q.push_back(o_diag);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic tmo();
    $display("MISMATCH %0t wait ran out", $time);
    n_fail++;
    end_of_test();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] pd(input int port, input logic [15:0] c);
    return {16'(port + 1), c};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int j;
    bit da, dw;
    da = 1'b0;
    dw = 1'b0;
    i_axi_awaddr <= a;
    i_axi_wdata <= d;
    i_axi_wstrb <= 4'hf;
    i_axi_awvalid <= 1'b1;
    i_axi_wvalid <= 1'b1;
    for (j = 0; j < 50 && !(da && dw); j++) begin
      cyc(1);
      if (!da && o_axi_awready === 1'b1) begin
        da = 1'b1;
        i_axi_awvalid <= 1'b0;
      end
      if (!dw && o_axi_wready === 1'b1) begin
        dw = 1'b1;
        i_axi_wvalid <= 1'b0;
      end
    end
    if (j == 50) tmo();
    i_axi_bready <= 1'b1;
    for (j = 0; j < 50 && o_axi_bvalid !== 1'b1; j++) cyc(1);
    if (j == 50) tmo();
    check(32'(o_axi_bresp), 32'(er));
    i_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    int j;
    bit got;
    got = 1'b0;
    i_axi_araddr <= a;
    i_axi_arvalid <= 1'b1;
    for (j = 0; j < 50 && !got; j++) begin
      cyc(1);
      got = (o_axi_arready === 1'b1);
    end
    if (!got) tmo();
    i_axi_arvalid <= 1'b0;
    i_axi_rready <= 1'b1;
    got = 1'b0;
    for (j = 0; j < 50 && !got; j++) begin
      cyc(1);
      got = (o_axi_rvalid === 1'b1);
    end
    if (!got) tmo();
    rd_d = o_axi_rdata;
    rd_r = o_axi_rresp;
    i_axi_rready <= 1'b0;
  endtask
  task automatic exp_diag(input logic [31:0] e);
    int j;
    for (j = 0; j < 2000 && q.size() == 0; j++) cyc(1);
    if (j == 2000) tmo();
    check(q.pop_front(), e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h01e6c066;
    n_fail = 0;
    samples_checked = 0;
    i_rstn = 1'b0;
    {i_us_fault, i_ul_fault, i_aux_fault, stall} = 7'h00;
    {i_ls_short, i_do_short, i_do_cmd} = 24'h000000;
    {i_axi_awvalid, i_axi_wvalid, i_axi_bready} = 3'h0;
    {i_axi_arvalid, i_axi_rready, i_axi_wstrb} = 6'h00;
    {i_axi_awaddr, i_axi_araddr, i_axi_wdata} = 48'h0;
    repeat (16) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    cyc(1);
    rd(`SSDM_A_CTRL);
    check(rd_d, 32'h1);
    rd(`SSDM_A_FILT);
    check(rd_d, 32'h50);
    rd(8'h18);
    check(32'(rd_r), 32'(`SSDM_RESP_ERR));
    wr(8'h1c, 32'h0, `SSDM_RESP_ERR);
    i_us_fault <= 1'b1;
    exp_diag(32'h80000002);
    check(32'(o_us_led), 32'(SSDM_LED_RED));
    i_us_fault <= 1'b0;
    wr(`SSDM_A_CTRL, 32'h0, `SSDM_RESP_OK);
    {i_us_fault, i_ul_fault} <= 2'h3;
    cyc(40);
    check(q.size(), 0);
    check(32'(o_us_led), 32'(SSDM_LED_OFF));
    check(32'(o_act_led), 32'(SSDM_LED_OFF));
    {i_us_fault, i_ul_fault} <= 2'h0;
    wr(`SSDM_A_CTRL, 32'h7, `SSDM_RESP_OK);
    i_ul_fault <= 1'b1;
    exp_diag(32'h80000118);
    check(32'(o_act_led), 32'(SSDM_LED_RED));
    i_ul_fault <= 1'b0;
    i_aux_fault <= 1'b1;
    exp_diag(32'h8000180e);
    check(32'(o_act_led), 32'(SSDM_LED_RED));
    i_aux_fault <= 1'b0;
    for (p = 0; p < 8; p++) begin
      stall <= 4'(rnd());
      i_ls_short <= 8'h01 << p;
      exp_diag(pd(p, `SSDM_CODE_LS));
      check(32'(o_port_fault_indicator[p]), 32'h1);
      i_ls_short <= 8'h00;
      cyc(3);
    end
    // auto restart with no filter: fault, forced off, retried later
    wr(`SSDM_A_CTRL, 32'h1, `SSDM_RESP_OK);
    wr(`SSDM_A_FILT, 32'h0, `SSDM_RESP_OK);
    i_do_cmd <= 8'hff;
    cyc(5);
    p = int'(rnd() & 32'h7);
    i_do_short <= 8'h01 << p;
    exp_diag(pd(p, `SSDM_CODE_DO));
    check(32'(o_do_en[p]), 32'h0);
    check(32'(o_port_fault_indicator[p]), 32'h1);
    for (k = 0; k < 1000 && o_do_en[p] !== 1'b1; k++) cyc(1);
    check(32'(o_do_en[p]), 32'h1);
    i_do_short <= 8'h00;
    cyc(10);
    // restart after reset, 10 ms window after the output rises
    wr(`SSDM_A_FILT, 32'ha, `SSDM_RESP_OK);
    wr(`SSDM_A_CTRL, 32'h9, `SSDM_RESP_OK);
    i_do_cmd <= ~(8'h01 << p);
    cyc(4);
    i_do_short <= 8'h01 << p;
    i_do_cmd <= 8'hff;
    q.delete();
    cyc(25);
    check(q.size(), 0);
    exp_diag(pd(p, `SSDM_CODE_DO));
    cyc(500);
    check(32'(o_do_en[p]), 32'h0);
    i_do_short <= 8'h00;
    i_do_cmd <= ~(8'h01 << p);
    cyc(4);
    i_do_cmd <= 8'hff;
    cyc(6);
    check(32'(o_do_en[p]), 32'h1);
    // supply loss with all outputs on: global plus per-port errors
    wr(`SSDM_A_CTRL, 32'h3, `SSDM_RESP_OK);
    wr(`SSDM_A_FILT, 32'h0, `SSDM_RESP_OK);
    cyc(60);
    rd(`SSDM_A_STAT);
    wr(`SSDM_A_MASK, 32'h2, `SSDM_RESP_OK);
    q.delete();
    stall <= 4'h7;
    i_ul_fault <= 1'b1;
    cyc(20);
    check(32'(o_irq), 32'h1);
    rd(`SSDM_A_STAT);
    check(rd_d, 32'h0007f802);
    cyc(3);
    check(32'(o_irq), 32'h0);
    exp_diag(32'h80000118);
    i_ul_fault <= 1'b0;
    cyc(20);
    end_of_test();
  end
endmodule // testbench
